/* design/ldpsc_pkg.sv */
// Shared constants for the LED dimming PWM and switching clock block
package ldpsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;          // System clock rate
  localparam int CLK_PERIOD_NS = 40;           // System clock period
  localparam int MIN_OFF_NS = 50;              // Least switch off time per cycle
  localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Switching clock oscillator
  // ----------------------------------------------------------------
  localparam int ACC_W = 20;                   // Phase accumulator width
  localparam int SW_STEP_HZ = 100_000;         // Frequency step per select code
  localparam int NCO_STEP = int'((64'd1 << ACC_W) * 64'(SW_STEP_HZ) / 64'(CLK_HZ));
  localparam int SW_SEL_BASE = 3;              // Code 0 means 0.3 MHz
  localparam int SW_SEL_MAX = 17;              // Code 17 means 2 MHz
  localparam int SCALE_SHIFT = 5;              // Frequency scale in 1/32 units
  localparam int SCALE_ONE = 32;               // 100 percent
  localparam int RAMP_START = 13;              // About 40 percent after a restart
  localparam int RAMP_CYCLES = 16;             // Switching cycles per ramp step
  localparam int SPREAD_MAX = 8;               // 25 percent above nominal
  localparam int SPREAD_SPECTRUM_MOD_HZ = 9_000;              // Modulation repeat rate
  localparam int SPREAD_SPECTRUM_MOD_PHASES = 18;             // Up, dwell, down, dwell
  localparam int SPREAD_SPECTRUM_MOD_TICK = CLK_HZ / (SPREAD_SPECTRUM_MOD_HZ * SPREAD_SPECTRUM_MOD_PHASES);

  // ----------------------------------------------------------------
  // Dimming generator
  // ----------------------------------------------------------------
  localparam int DIM_SLOTS = 4096;             // Slots per dimming period
  localparam int DIM_HZ_STEP = 100;            // Free running rate per select code
  localparam int DIM_SEL_MAX = 4;              // Code 4 means 500 Hz
  localparam int DIM_MV_LO = 200;              // Lower span limit in mV
  localparam int DIM_MV_HI = 1200;             // Upper span limit in mV
  localparam int QUANT_MUL = 131;              // 128/1000 scaled by 1024
  localparam int QUANT_SHIFT = 10;
  localparam int CODE_MAX = 127;
  localparam int DUTY_RATIO_NUM = 246;         // Ratio between codes, 246/256
  localparam int DUTY_RATIO_SHIFT = 8;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_W = 12;
  localparam int F_SW_SEL = 0;                 // [4:0] switching frequency code
  localparam int F_DIM_SEL = 5;                // [7:5] dimming frequency code
  localparam int F_DIM_FROM_SW = 8;            // Dimming clock from switching clock
  localparam int F_DIM_INT = 9;                // Internal dimming mode
  localparam int F_SPREAD_EN = 10;             // Spread spectrum on
  localparam int F_SYNC_EN = 11;               // External clock sync on
  localparam int S_CODE = 0;                   // [6:0] active code
  localparam int S_RAMP_DONE = 7;
  localparam int S_RUN = 8;
  localparam int S_SPREAD = 9;                 // [12:9] spread offset

  // Slot divider for a free running dimming rate code
  function automatic int slot_div(input int sel);
    return CLK_HZ / (DIM_HZ_STEP * (sel + 1) * DIM_SLOTS);
  endfunction : slot_div

  // On slots for a code; each code below the top scales by the fixed ratio
  function automatic logic [12:0] duty_of(input int code);
    int d;
    int p;
    d = DIM_SLOTS;
    for (int i = CODE_MAX; i > code; i--) begin
      p = d;
      d = (d * DUTY_RATIO_NUM) >> DUTY_RATIO_SHIFT;
      if (d >= p) begin
        d = p - 1;
      end
    end
    return 13'(d);
  endfunction : duty_of

endpackage : ldpsc_pkg

/* design/ldpsc_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ldpsc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import ldpsc_pkg::*;

  logic [W-1:0] meta_reg; // First stage, read only by the second stage
  logic [W-1:0] q_reg; // Second stage, safe to use

  // ----------------------------------------------------------------
  // Two stage capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule : ldpsc_sync2

/* design/ldpsc_top.sv */
// Switching clock and dimming PWM generator with a Wishbone register port
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module ldpsc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dim_pin_i,
  input wire logic [10:0] dim_level_i,
  input wire logic sync_spread_i,
  input wire logic demand_i,
  input wire logic fault_restart_i,
  output logic switch_on_o,
  output logic load_disconnect_gate_o,
  output logic comp_node_hiz_o,
  output logic sw_cycle_o
);
  import ldpsc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_sync; // Synchronised pin levels
  logic dim_sync; // Dimming pin level
  logic sync_sync; // Sync clock level
  logic demand_sync; // Loop demand
  logic fault_sync; // Fault restart request

  ldpsc_sync2 #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({fault_restart_i, demand_i, sync_spread_i, dim_pin_i}),
    .q_o(pins_sync)
  );
  assign {fault_sync, demand_sync, sync_sync, dim_sync} = pins_sync;

  // ----------------------------------------------------------------
  // Constant tables
  // ----------------------------------------------------------------
  logic [12:0] duty_lut [0:CODE_MAX]; // On slots per code
  logic [7:0] slot_div_tab [0:DIM_SEL_MAX]; // Clock cycles per dimming slot

  for (genvar g = 0; g <= CODE_MAX; g++) begin : g_duty
    assign duty_lut[g] = duty_of(g);
  end
  for (genvar g = 0; g <= DIM_SEL_MAX; g++) begin : g_div
    assign slot_div_tab[g] = 8'(slot_div(g));
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // Mode and rate settings
  logic ack_reg, ack_next; // Bus answer
  logic [31:0] rdat_reg, rdat_next; // Bus read data
  logic [ACC_W-1:0] acc_reg, acc_next; // Switching phase
  logic [5:0] ramp_reg, ramp_next; // Ramp scale in 1/32
  logic [3:0] rcnt_reg, rcnt_next; // Cycles at this ramp step
  logic [7:0] stick_reg, stick_next; // Spread phase timer
  logic [4:0] sphase_reg, sphase_next; // Spread triangle phase
  logic sync_d_reg, sync_d_next; // Sync level one cycle back
  logic sw_reg, sw_next; // Switch drive
  logic cyc_reg, cyc_next; // Cycle start marker
  logic gate_reg, gate_next; // Disconnect gate off
  logic hiz_reg, hiz_next; // Compensation node released
  logic [7:0] sdiv_reg, sdiv_next; // Slot divider
  logic [11:0] slot_reg, slot_next; // Slot within dimming period
  logic [6:0] code_reg, code_next; // Code in force this period

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [4:0] sw_sel; // Clamped frequency code
  logic [2:0] dim_sel; // Clamped dimming rate code
  logic [16:0] inc_nom; // Nominal phase step
  logic [3:0] spread_off; // Spread offset in 1/32
  logic [5:0] scale; // Total frequency scale
  logic [17:0] inc_eff; // Phase step in use
  logic [ACC_W:0] acc_sum; // Phase plus step with carry
  logic [ACC_W+1:0] off_look; // Phase a few steps ahead
  logic wrap; // Internal oscillator wraps
  logic sync_edge; // Rising edge of sync clock
  logic cyc_start; // A switching cycle begins
  logic force_off; // Inside the minimum off window
  logic slot_tick; // One dimming slot passes
  logic period_end; // Last slot of a dimming period
  logic [6:0] code_raw; // Quantised dimming level
  logic [21:0] qprod; // Quantiser product
  logic run; // Converter may switch
  logic wr_ctrl; // Write strobe for the control register
  logic [31:0] status_word; // Status read value

  // Clamp out of range settings to the top entry rather than wrapping
  always_comb begin
    sw_sel = (ctrl_reg[F_SW_SEL +: 5] > 5'(SW_SEL_MAX)) ? 5'(SW_SEL_MAX)
                                                        : ctrl_reg[F_SW_SEL +: 5];
    dim_sel = (ctrl_reg[F_DIM_SEL +: 3] > 3'(DIM_SEL_MAX)) ? 3'(DIM_SEL_MAX)
                                                           : ctrl_reg[F_DIM_SEL +: 3];
    inc_nom = 17'((int'(sw_sel) + SW_SEL_BASE) * NCO_STEP);
  end

  // Triangle: rise 0..8, dwell at 8, fall 7..0, dwell at 0
  always_comb begin
    if (!ctrl_reg[F_SPREAD_EN] || ctrl_reg[F_SYNC_EN] || ramp_reg != 6'(SCALE_ONE)) begin
      spread_off = 4'h0;
    end else if (sphase_reg <= 5'(SPREAD_MAX)) begin
      spread_off = sphase_reg[3:0];
    end else if (sphase_reg == 5'(SPREAD_MAX + 1)) begin
      spread_off = 4'(SPREAD_MAX);
    end else begin
      spread_off = 4'(5'(SPREAD_SPECTRUM_MOD_PHASES - 1) - sphase_reg);
    end
    scale = ramp_reg + 6'(spread_off);
    inc_eff = 18'((23'(inc_nom) * 23'(scale)) >> SCALE_SHIFT);
    acc_sum = {1'b0, acc_reg} + 21'(inc_eff);
    wrap = acc_sum[ACC_W];
    sync_edge = sync_sync && !sync_d_reg;
    // With sync on, the edge alone starts a cycle
    cyc_start = ctrl_reg[F_SYNC_EN] ? sync_edge : wrap;
  end

  // Quantise the level linearly and clamp at the span ends
  always_comb begin
    qprod = 22'(dim_level_i - 11'(DIM_MV_LO)) * 22'(QUANT_MUL);
    if (dim_level_i < 11'(DIM_MV_LO)) begin
      code_raw = 7'h00;
    end else if (dim_level_i >= 11'(DIM_MV_HI) || qprod[21:QUANT_SHIFT] > 12'(CODE_MAX)) begin
      code_raw = 7'(CODE_MAX);
    end else begin
      code_raw = qprod[QUANT_SHIFT +: 7];
    end
  end

  // ----------------------------------------------------------------
  // Switching clock
  // ----------------------------------------------------------------
  always_comb begin
    sync_d_next = sync_sync;
    if (ctrl_reg[F_SYNC_EN] && sync_edge) begin
      acc_next = '0;
    end else if (ctrl_reg[F_SYNC_EN] && wrap) begin
      acc_next = '1; // Hold at the top until the external edge
    end else begin
      acc_next = acc_sum[ACC_W-1:0];
    end
    off_look = {1'b0, acc_sum} + 22'(MIN_OFF_CYC * int'(inc_eff));
    force_off = !cyc_start && off_look[ACC_W+1:ACC_W] != 2'b00;
    // Restart ramp: low rate after reset or fault, one step per 16 cycles
    ramp_next = ramp_reg;
    rcnt_next = rcnt_reg;
    if (fault_sync) begin
      ramp_next = 6'(RAMP_START);
      rcnt_next = 4'h0;
    end else if (cyc_start && ramp_reg != 6'(SCALE_ONE)) begin
      rcnt_next = rcnt_reg + 4'h1;
      if (rcnt_reg == 4'(RAMP_CYCLES - 1)) begin
        ramp_next = ramp_reg + 6'h01;
      end
    end
    // Spread phase timer, about 9 kHz per full triangle
    stick_next = stick_reg + 8'h01;
    sphase_next = sphase_reg;
    if (stick_reg == 8'(SPREAD_SPECTRUM_MOD_TICK - 1)) begin
      stick_next = 8'h00;
      sphase_next = (sphase_reg == 5'(SPREAD_SPECTRUM_MOD_PHASES - 1)) ? 5'h00 : sphase_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Dimming generator
  // ----------------------------------------------------------------
  always_comb begin
    // Rail mode counts switching cycles, free mode its own divider
    sdiv_next = sdiv_reg + 8'h01;
    if (ctrl_reg[F_DIM_FROM_SW]) begin
      slot_tick = cyc_start;
      sdiv_next = 8'h00;
    end else begin
      slot_tick = sdiv_reg >= slot_div_tab[dim_sel] - 8'h01;
      if (slot_tick) begin
        sdiv_next = 8'h00;
      end
    end
    period_end = slot_tick && slot_reg == 12'(DIM_SLOTS - 1);
    slot_next = slot_tick ? slot_reg + 12'h001 : slot_reg;
    // A new code only at the period boundary, never mid-period
    code_next = period_end ? code_raw : code_reg;
    if (ctrl_reg[F_DIM_INT]) begin
      run = 13'(slot_reg) < duty_lut[code_reg];
    end else begin
      run = dim_sync;
    end
    gate_next = !run;
    hiz_next = !run;
    // Switch on at cycle start, off on demand loss or in the off window
    if (!run || force_off || !demand_sync) begin
      sw_next = 1'b0;
    end else if (cyc_start) begin
      sw_next = 1'b1;
    end else begin
      sw_next = sw_reg;
    end
    cyc_next = cyc_start;
  end

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[S_CODE +: 7] = code_reg;
    status_word[S_RAMP_DONE] = ramp_reg == 6'(SCALE_ONE);
    status_word[S_RUN] = !gate_reg;
    status_word[S_SPREAD +: 4] = spread_off;
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    wr_ctrl = ack_next && wb_we_i && wb_adr_i == REG_CTRL;
    ctrl_next = ctrl_reg;
    if (wr_ctrl && wb_sel_i[0]) begin
      ctrl_next[7:0] = wb_dat_i[7:0];
    end
    if (wr_ctrl && wb_sel_i[1]) begin
      ctrl_next[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
    end
    unique case (wb_adr_i)
      REG_CTRL: rdat_next = 32'(ctrl_reg);
      REG_STATUS: rdat_next = status_word;
      default: rdat_next = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_W'(CTRL_RST);
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      acc_reg <= '0;
      ramp_reg <= 6'(RAMP_START);
      rcnt_reg <= 4'h0;
      stick_reg <= 8'h00;
      sphase_reg <= 5'h00;
      sync_d_reg <= 1'b0;
      sw_reg <= 1'b0;
      cyc_reg <= 1'b0;
      gate_reg <= 1'b1;
      hiz_reg <= 1'b1;
      sdiv_reg <= 8'h00;
      slot_reg <= 12'h000;
      code_reg <= 7'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      acc_reg <= acc_next;
      ramp_reg <= ramp_next;
      rcnt_reg <= rcnt_next;
      stick_reg <= stick_next;
      sphase_reg <= sphase_next;
      sync_d_reg <= sync_d_next;
      sw_reg <= sw_next;
      cyc_reg <= cyc_next;
      gate_reg <= gate_next;
      hiz_reg <= hiz_next;
      sdiv_reg <= sdiv_next;
      slot_reg <= slot_next;
      code_reg <= code_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign switch_on_o = sw_reg;
  assign load_disconnect_gate_o = gate_reg;
  assign comp_node_hiz_o = hiz_reg;
  assign sw_cycle_o = cyc_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_halt_no_switch: assert property (load_disconnect_gate_o |-> !switch_on_o)
    else $error("switch active while dimming is off");
  a_hiz_with_halt: assert property (comp_node_hiz_o == load_disconnect_gate_o)
    else $error("compensation release not tied to halt");
  a_ext_gate_off: assert property (
    (!ctrl_reg[F_DIM_INT] && !dim_sync) |=> load_disconnect_gate_o)
    else $error("gate not off with external dimming low");
  a_min_off_kept: assert property (force_off |=> !switch_on_o)
    else $error("switch on inside minimum off window");
  a_ramp_restart: assert property (fault_sync |=> ramp_reg == 6'(RAMP_START))
    else $error("ramp not reset by fault restart");
  a_ramp_one_step: assert property (
    ($changed(ramp_reg) && !$past(fault_sync)) |-> ramp_reg == $past(ramp_reg) + 6'h01
      && $past(cyc_start) && $past(rcnt_reg) == 4'(RAMP_CYCLES - 1))
    else $error("ramp step without 16 cycles");
  a_rail_slot_src: assert property (
    (ctrl_reg[F_DIM_FROM_SW] && !cyc_start) |=> slot_reg == $past(slot_reg))
    else $error("rail mode slot moved without switching cycle");
  a_code_boundary: assert property ($changed(code_reg) |-> $past(period_end))
    else $error("code changed inside a dimming period");
  a_code_clamp_lo: assert property (dim_level_i < 11'(DIM_MV_LO) |-> code_raw == 7'h00)
    else $error("level below span not code zero");
  a_spread_bound: assert property (scale <= 6'(SCALE_ONE + SPREAD_MAX))
    else $error("frequency scale above 125 percent");
  a_full_duty_top: assert property (
    (ctrl_reg[F_DIM_INT] && code_reg == 7'(CODE_MAX)) |=> !load_disconnect_gate_o)
    else $error("top code not fully on");
  a_sync_restart: assert property (
    (ctrl_reg[F_SYNC_EN] && sync_edge) |=> acc_reg == '0 ##0 sw_cycle_o)
    else $error("sync edge did not start a cycle");

  c_spread_peak: cover property (spread_off == 4'(SPREAD_MAX) ##1 spread_off == 4'(SPREAD_MAX));
  c_ramp_done: cover property ($rose(ramp_reg == 6'(SCALE_ONE)));
  c_ext_resume: cover property ($fell(load_disconnect_gate_o) && !ctrl_reg[F_DIM_INT]);
  c_period_code: cover property (period_end && ctrl_reg[F_DIM_INT]);

endmodule : ldpsc_top

/* verification/ldpsc_ctrl_model.sv */
// Outside controller model: dimming pin level and external sync clock
`timescale 1ns/1ps
module ldpsc_ctrl_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic sync_on_i,
  input wire logic [7:0] sync_per_i,
  output logic dim_pin_o,
  output logic sync_spread_o
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [7:0] cnt_reg = 8'h00; // Position in the sync period
  logic dim_reg = 1'b0; // Dimming pin level, idle low
  logic sync_reg = 1'b0; // Sync pin level, idle low
  // Pins move only after a rising edge; sync stands low when not sent
  always @(posedge clk_i) begin
    dim_reg <= run_i; // Held high to run on, low to stay idle
    cnt_reg <= (cnt_reg >= sync_per_i - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
    // Bench picks a period close to the programmed rate
    sync_reg <= sync_on_i && (cnt_reg < (sync_per_i >> 1));
  end
  assign dim_pin_o = dim_reg;
  assign sync_spread_o = sync_reg;
endmodule : ldpsc_ctrl_model

/* verification/ldpsc_top_tb.sv */
// Self-checking bench for the switching clock and dimming generator
`timescale 1ns/1ps
module ldpsc_top_tb;
  import ldpsc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dim_pin_i, sync_spread_i, switch_on_o, gate, hiz, sw_cycle_o;
  logic [10:0] dim_level_i = 11'h000;
  logic demand_i = 1'b1;
  logic fault_restart_i = 1'b0;
  logic run = 1'b0;
  logic sync_on = 1'b0;
  logic [31:0] rd, p, o, mn, mx;
  int n_errors = 0;
  int tests_run = 0;

  ldpsc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dim_pin_i(dim_pin_i), .dim_level_i(dim_level_i),
    .sync_spread_i(sync_spread_i), .demand_i(demand_i), .fault_restart_i(fault_restart_i),
    .switch_on_o(switch_on_o), .load_disconnect_gate_o(gate), .comp_node_hiz_o(hiz),
    .sw_cycle_o(sw_cycle_o));
  ldpsc_ctrl_model u_ctrl (.clk_i(clk_i), .run_i(run), .sync_on_i(sync_on),
    .sync_per_i(8'h50), .dim_pin_o(dim_pin_i), .sync_spread_o(sync_spread_i));

  // ----------------------------------------------------------------
  // Clock, tasks and watchdog
  // ----------------------------------------------------------------
  always #20 clk_i = ~clk_i;

  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; ack and data taken at the rising edge, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) n_errors++;
  endtask : wb

  // Length of one switching cycle and clocks with the switch on in it
  task automatic meas(output logic [31:0] pp, output logic [31:0] oo);
    int n;
    n = 0;
    pp = 0;
    oo = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (sw_cycle_o !== 1'b1 && n < 400);
    do begin
      @(negedge clk_i);
      pp++;
      if (switch_on_o === 1'b1) oo++;
    end while (sw_cycle_o !== 1'b1 && pp < 400);
    if (n >= 400 || pp >= 400) n_errors++;
  endtask : meas

  // Whole run is near 72k clocks; cut off before 100k
  initial begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({28'h0, gate, hiz, switch_on_o, wb_ack_o}, 32'hC);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    chk(rd, CTRL_RST);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, REG_CTRL, 32'hFFFF_F011, rd);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    chk(rd, 32'h11);
    meas(p, o);
    chk({gate, o[30:0]}, 32'h8000_0000);
    run <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk({30'h0, gate, hiz}, 32'h0);
    meas(p, o);
    chk(32'(p == 30 || p == 31), 32'h1);
    chk(32'(o > 0 && o <= p - MIN_OFF_CYC), 32'h1);
    repeat (8000) @(posedge clk_i);
    meas(p, o);
    chk(32'(p == 12 || p == 13), 32'h1);
    chk(32'(o > 0 && o <= p - MIN_OFF_CYC), 32'h1);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk(32'(rd[S_RAMP_DONE]), 32'h1);
    fault_restart_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    fault_restart_i <= 1'b0;
    meas(p, o);
    meas(p, o);
    chk(32'(p == 30 || p == 31), 32'h1);
    repeat (8000) @(posedge clk_i);
    wb(1'b1, REG_CTRL, 32'h411, rd);
    mn = 400;
    mx = 0;
    repeat (300) begin
      meas(p, o);
      if (p < mn) mn = p;
      if (p > mx) mx = p;
    end
    chk(32'(mn == 10 && mx >= 12), 32'h1);
    wb(1'b1, REG_CTRL, 32'h800, rd);
    sync_on <= 1'b1;
    meas(p, o);
    meas(p, o);
    chk(p, 32'd80);
    sync_on <= 1'b0;
    @(posedge clk_i);
    dim_level_i <= 11'd1300;
    wb(1'b1, REG_CTRL, 32'h311, rd);
    rd = 32'h0;
    for (int i = 0; i < 130 && rd[6:0] !== 7'h7F; i++) begin
      repeat (500) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0, rd);
    end
    chk(32'(rd[6:0]), 32'h7F);
    o = 0;
    repeat (2000) begin
      @(negedge clk_i);
      if (gate !== 1'b0 || hiz !== 1'b0) o++;
    end
    chk(o, 32'h0);
    dim_level_i <= 11'd100;
    repeat (20) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk(32'(rd[6:0]), 32'h7F);
    stop_test();
  end
endmodule : ldpsc_top_tb
